// ---- iart_map.svh ----
// Constants of the I2C alias remap table: offsets, fields and reset values.
// Assumes inclusion by bare name from the design modules iart_alias_match and iart_top.
//
// How it works
// - Entry-7 target address in bits 7:1, reset zero.
// - Alias-7 match substitutes entry-7 target address.
// - Remote side delivers remapped transaction to target.
// - Zero entry-7 target blocks access through alias 7.
// - Aliases 0-4 hold 7-bit address, nonzero accepts.
// - Alias n remaps to target entry n.
// - Zero alias field never matches any address.
// - Targets 0-6 precede entry 7, same behaviour.
// - Aliases 5-7 follow alias 4, same behaviour.
`ifndef IART_MAP_SVH
`define IART_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define IART_TGT_BASE      8'h08
`define IART_TGT7_OFS      8'h0f
`define IART_ALIAS_BASE    8'h10
`define IART_ALIAS0_OFS    8'h10
`define IART_ALIAS1_OFS    8'h11
`define IART_ALIAS2_OFS    8'h12
`define IART_ALIAS3_OFS    8'h13
`define IART_ALIAS4_OFS    8'h14
`define IART_ALIAS5_OFS    8'h15
`define IART_BANK_MASK     8'hf8

// ----------------------------------------
// Field layout and reset values
// ----------------------------------------
`define IART_ADDR_MSB      7
`define IART_ADDR_LSB      1
`define IART_RSVD_BIT      0
`define IART_ADDR_RST      7'h00
`define IART_RDATA_RST     8'h00
`define IART_ENTRIES       8

`endif

// ---- iart_pkg.sv ----
// Types shared by the alias remap table modules.
// Assumes the constants header is on the include path.
`default_nettype none
package iart_pkg;
    // Seven-bit I2C address
    typedef logic [6:0] iart_addr_t;
    // Entry index 0..7
    typedef logic [2:0] iart_idx_t;
    // Lookup sequencer states, one-hot
    typedef enum logic [2:0] {
        IART_IDLE  = 3'b001,
        IART_MATCH = 3'b010,
        IART_SEND  = 3'b100
    } iart_state_t;
endpackage

`default_nettype wire

// ---- iart_alias_match.sv ----
// Alias comparator: finds the table entry whose alias equals an address.
// Assumes alias and target tables arrive as registered values.
`timescale 1ns/1ns
`default_nettype none
`include "iart_map.svh"

module iart_alias_match (
    input  wire logic [7:0][6:0]     alias_tab,  // Local alias per entry
    input  wire logic [7:0][6:0]     tgt_tab,    // Remote target per entry
    input  wire iart_pkg::iart_addr_t addr,      // Address under test
    output logic                     hit,        // Some alias matched
    output iart_pkg::iart_idx_t      hit_idx,    // Lowest matching entry
    output iart_pkg::iart_addr_t     hit_tgt     // Target of that entry
);
    logic [7:0] ent_hit;

    // ----------------------------------------
    // Per-entry compare
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < `IART_ENTRIES; g = g + 1) begin : g_ent
            // Zero alias is disabled and matches nothing
            assign ent_hit[g] = (alias_tab[g] != `IART_ADDR_RST) &&
                                (alias_tab[g] == addr);
        end
    endgenerate

    // Priority pick, lowest index wins
    always_comb begin
        hit     = 1'b0;
        hit_idx = 3'h0;
        hit_tgt = `IART_ADDR_RST;
        for (int i = `IART_ENTRIES - 1; i >= 0; i = i - 1) begin
            if (ent_hit[i]) begin
                hit     = 1'b1;
                hit_idx = 3'(i);
                hit_tgt = tgt_tab[i];
            end
        end
    end
endmodule

`default_nettype wire

// ---- iart_top.sv ----
// Alias remap table: alias and remote target registers plus lookup.
// A lookup answers two edges after it is taken: a forward request
// or a one-cycle refusal, with one lookup outstanding at a time.
// Assumes the I2C slave engine drives the register port and the
// local request port, and the control channel takes forward requests.
`timescale 1ns/1ns
`default_nettype none
`include "iart_map.svh"

module iart_top (
    input  wire logic                 ref_clk,     // Core clock, 100 MHz
    input  wire logic                 reset_n,     // Async reset, active low
    input  wire logic [7:0]           reg_addr,    // Register offset
    input  wire logic                 reg_wr_en,   // Write strobe
    input  wire logic [7:0]           reg_wdata,   // Write data
    input  wire logic                 reg_rd_en,   // Read strobe
    output logic [7:0]                reg_rdata,   // Read data, next cycle
    output logic                      reg_rd_hit,  // Read hit a table reg
    input  wire logic                 req_valid,   // Local transaction start
    input  wire iart_pkg::iart_addr_t req_addr,    // Local target address
    input  wire logic                 req_rnw,     // Read not write
    output logic                      req_ready,   // Ready for a request
    output logic                      req_nack,    // Pulse: not accepted
    output logic                      fwd_valid,   // Forward request valid
    output iart_pkg::iart_addr_t      fwd_addr,    // Remapped remote address
    output logic                      fwd_rnw,     // Forwarded direction
    output iart_pkg::iart_idx_t       fwd_entry,   // Remote target index
    input  wire logic                 fwd_ready    // Channel takes request
);
    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    logic [7:0][6:0] tgt_q;
    logic [7:0][6:0] tgt_d;
    logic [7:0][6:0] alias_q;
    logic [7:0][6:0] alias_d;
    logic [7:0]      rdata_q;
    logic [7:0]      rdata_d;
    logic            rd_hit_q;
    logic            rd_hit_d;
    logic            tgt_bank;
    logic            alias_bank;
    logic [2:0]      reg_idx;
    logic [7:0]      tgt_wr_sel;
    logic [7:0]      alias_wr_sel;
    logic [6:0]      wr_field;
    logic [6:0]      rd_field;
    logic            rd_in_table;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // Bank decode, eight entries per bank
    assign tgt_bank    = ((reg_addr & `IART_BANK_MASK) == `IART_TGT_BASE);
    assign alias_bank  = ((reg_addr & `IART_BANK_MASK) == `IART_ALIAS_BASE);
    assign rd_in_table = tgt_bank || alias_bank;
    assign reg_idx     = reg_addr[2:0];

    // Only bits 7:1 are stored, bit 0 is dropped
    assign wr_field = reg_wdata[`IART_ADDR_MSB:`IART_ADDR_LSB];

    // One write select per table entry
    genvar e;
    generate
        for (e = 0; e < `IART_ENTRIES; e = e + 1) begin : g_wsel
            // Target e; entry 7 closes the target bank
            assign tgt_wr_sel[e]   = reg_wr_en && tgt_bank && (reg_idx == 3'(e));
            // Alias e; aliases 5 to 7 follow alias 4
            assign alias_wr_sel[e] = reg_wr_en && alias_bank && (reg_idx == 3'(e));
        end
    endgenerate

    // ----------------------------------------
    // Table registers
    // ----------------------------------------
    // Next values: new field where selected, else hold
    always_comb begin
        tgt_d   = tgt_q;
        alias_d = alias_q;
        for (int i = 0; i < `IART_ENTRIES; i = i + 1) begin
            if (tgt_wr_sel[i]) begin
                tgt_d[i] = wr_field;
            end
            if (alias_wr_sel[i]) begin
                alias_d[i] = wr_field;
            end
        end
    end

    // Table registers, all reset to zero
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tgt_q   <= '0;
            alias_q <= '0;
        end else begin
            tgt_q   <= tgt_d;
            alias_q <= alias_d;
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    // Old field of the addressed entry, even on a same-cycle write
    assign rd_field = tgt_bank ? tgt_q[reg_idx] : alias_q[reg_idx];

    // Read data moves only on a read strobe
    always_comb begin
        rdata_d  = rdata_q;
        rd_hit_d = 1'b0;
        if (reg_rd_en) begin
            if (rd_in_table) begin
                rdata_d  = {rd_field, 1'b0};
                rd_hit_d = 1'b1;
            end else begin
                // Outside the table: zero and no hit
                rdata_d = `IART_RDATA_RST;
            end
        end
    end

    // Read port registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q  <= `IART_RDATA_RST;
            rd_hit_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rd_hit_q <= rd_hit_d;
        end
    end

    assign reg_rdata  = rdata_q;
    assign reg_rd_hit = rd_hit_q;

    // ----------------------------------------
    // Alias lookup
    // ----------------------------------------
    iart_pkg::iart_addr_t lat_addr_q;
    iart_pkg::iart_addr_t lat_addr_d;
    logic                 lat_rnw_q;
    logic                 lat_rnw_d;
    logic                 m_hit;
    iart_pkg::iart_idx_t  m_idx;
    iart_pkg::iart_addr_t m_tgt;

    // Compare latched address against every alias
    iart_alias_match u_match (
        .alias_tab (alias_q),
        .tgt_tab   (tgt_q),
        .addr      (lat_addr_q),
        .hit       (m_hit),
        .hit_idx   (m_idx),
        .hit_tgt   (m_tgt)
    );

    // ----------------------------------------
    // Request sequencer
    // ----------------------------------------
    iart_pkg::iart_state_t st_q;
    iart_pkg::iart_state_t st_d;
    logic                  ready_q;
    logic                  ready_d;
    logic                  nack_q;
    logic                  nack_d;
    logic                  fvalid_q;
    logic                  fvalid_d;
    iart_pkg::iart_addr_t  faddr_q;
    iart_pkg::iart_addr_t  faddr_d;
    logic                  frnw_q;
    logic                  frnw_d;
    iart_pkg::iart_idx_t   fentry_q;
    iart_pkg::iart_idx_t   fentry_d;

    logic                  take;
    logic                  accept;
    logic                  handoff;

    // ----------------------------------------
    // Lookup verdict
    // ----------------------------------------
    // Taken only while idle; a zero target blocks even an alias hit
    assign take    = (st_q == iart_pkg::IART_IDLE) && req_valid;
    assign accept  = (st_q == iart_pkg::IART_MATCH) && m_hit &&
                     (m_tgt != `IART_ADDR_RST);
    assign handoff = (st_q == iart_pkg::IART_SEND) && fwd_ready;

    // Next state: latch, match, then hold forward until taken
    always_comb begin
        st_d    = st_q;
        ready_d = ready_q;
        nack_d  = 1'b0;
        case (st_q)
            iart_pkg::IART_IDLE: begin
                if (take) begin
                    ready_d = 1'b0;
                    st_d    = iart_pkg::IART_MATCH;
                end
            end
            iart_pkg::IART_MATCH: begin
                if (accept) begin
                    st_d = iart_pkg::IART_SEND;
                end else begin
                    // No alias hit, or a hit on a zero target
                    nack_d  = 1'b1;
                    ready_d = 1'b1;
                    st_d    = iart_pkg::IART_IDLE;
                end
            end
            iart_pkg::IART_SEND: begin
                if (handoff) begin
                    ready_d = 1'b1;
                    st_d    = iart_pkg::IART_IDLE;
                end
            end
            default: begin
                ready_d = 1'b1;
                st_d    = iart_pkg::IART_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q    <= iart_pkg::IART_IDLE;
            ready_q <= 1'b1;
            nack_q  <= 1'b0;
        end else begin
            st_q    <= st_d;
            ready_q <= ready_d;
            nack_q  <= nack_d;
        end
    end

    // ----------------------------------------
    // Request latch
    // ----------------------------------------
    // Address and direction captured when a request is taken
    always_comb begin
        lat_addr_d = lat_addr_q;
        lat_rnw_d  = lat_rnw_q;
        if (take) begin
            lat_addr_d = req_addr;
            lat_rnw_d  = req_rnw;
        end
    end

    // Request latch registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            lat_addr_q <= `IART_ADDR_RST;
            lat_rnw_q  <= 1'b0;
        end else begin
            lat_addr_q <= lat_addr_d;
            lat_rnw_q  <= lat_rnw_d;
        end
    end

    // ----------------------------------------
    // Forward request
    // ----------------------------------------
    // Raised on accept, held until handed off, never up outside SEND
    always_comb begin
        fvalid_d = fvalid_q;
        faddr_d  = faddr_q;
        frnw_d   = frnw_q;
        fentry_d = fentry_q;
        if (accept) begin
            fvalid_d = 1'b1;
            faddr_d  = m_tgt;
            frnw_d   = lat_rnw_q;
            fentry_d = m_idx;
        end else if (handoff || (st_q != iart_pkg::IART_SEND)) begin
            fvalid_d = 1'b0;
        end
    end

    // Forward registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fvalid_q <= 1'b0;
            faddr_q  <= `IART_ADDR_RST;
            frnw_q   <= 1'b0;
            fentry_q <= 3'h0;
        end else begin
            fvalid_q <= fvalid_d;
            faddr_q  <= faddr_d;
            frnw_q   <= frnw_d;
            fentry_q <= fentry_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Outputs straight from flops
    assign req_ready = ready_q;
    assign req_nack  = nack_q;
    assign fwd_valid = fvalid_q;
    assign fwd_addr  = faddr_q;
    assign fwd_rnw   = frnw_q;
    assign fwd_entry = fentry_q;
endmodule

`default_nettype wire

// ---- iart_monitor.sv ----
// Checker for the remap table: register reads and lookup handshake.
// Assumes a bind to iart_top; sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module iart_monitor (
    input wire logic       ref_clk,    // Core clock
    input wire logic       reset_n,    // Async reset
    input wire logic [7:0] reg_addr,   // Register offset
    input wire logic       reg_rd_en,  // Read strobe
    input wire logic [7:0] reg_rdata,  // Read data
    input wire logic       reg_rd_hit, // Read hit
    input wire logic       req_valid,  // Request valid
    input wire logic       req_rnw,    // Direction
    input wire logic       req_ready,  // Idle
    input wire logic       req_nack,   // Refusal pulse
    input wire logic       fwd_valid,  // Forward valid
    input wire logic [6:0] fwd_addr,   // Remapped address
    input wire logic       fwd_rnw,    // Forward direction
    input wire logic [2:0] fwd_entry,  // Entry index
    input wire logic       fwd_ready   // Channel accept
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Request taken, then answer two edges later
    sequence s_take; req_valid && req_ready; endsequence
    sequence s_answer; !req_ready ##1 (fwd_valid ^ req_nack); endsequence
    a_lookup_answer: assert property (s_take |=> s_answer)
        else $error("lookup answer not at second edge");
    a_rnw_carry: assert property (s_take ##2 fwd_valid |-> fwd_rnw == $past(req_rnw, 2))
        else $error("direction not carried");
    a_fwd_hold: assert property (fwd_valid && !fwd_ready |=> fwd_valid && $stable(fwd_addr) && $stable(fwd_entry))
        else $error("forward request dropped or changed");
    a_fwd_done: assert property (fwd_valid && fwd_ready |=> !fwd_valid && req_ready)
        else $error("forward not released");
    a_zero_target: assert property (fwd_valid |-> fwd_addr != 7'h00)
        else $error("zero target forwarded");
    a_nack_pulse: assert property (req_nack |-> req_ready ##1 !req_nack)
        else $error("refusal not a single pulse");
    a_rd_window: assert property (reg_rd_en && reg_addr >= 8'h08 && reg_addr <= 8'h17 |=> reg_rd_hit)
        else $error("table read without hit");
    a_rsvd_zero: assert property (reg_rd_hit |-> !reg_rdata[0])
        else $error("reserved bit reads one");
    a_rd_hold: assert property (!reg_rd_en |=> !reg_rd_hit && $stable(reg_rdata))
        else $error("read data moved without read");
endmodule
`default_nettype wire

// ---- iart_chan_model.sv ----
// Control channel model taking forward requests after a set stall.
// Assumes the bench sets the stall between lookups.
`timescale 1ns/1ns
`default_nettype none
module iart_chan_model (
    input  wire logic       ref_clk,    // Core clock
    input  wire logic       reset_n,    // Async reset
    input  wire logic       fwd_valid,  // Forward valid
    input  wire logic [6:0] fwd_addr,   // Remapped address
    input  wire logic [3:0] stall,      // Wait cycles
    output logic            fwd_ready,  // Accept strobe
    output logic [6:0]      taken_addr  // Last delivered target
);
    logic [3:0] cnt_q;
    // Accept after stall, deliver to remote target
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 4'h0;
            fwd_ready <= 1'b0;
            taken_addr <= 7'h00;
        end else if (fwd_ready) begin
            fwd_ready <= 1'b0;
            cnt_q <= 4'h0;
            taken_addr <= fwd_addr;
        end else if (fwd_valid) begin
            fwd_ready <= cnt_q >= stall;
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ---- tb.sv ----
// Testbench: register access and lookups against the remap table.
// Assumes iart_top, the checker and the channel model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic ref_clk, reset_n, reg_wr_en, reg_rd_en, reg_rd_hit, req_valid, req_rnw;
    logic req_ready, req_nack, fwd_valid, fwd_rnw, fwd_ready;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [6:0] req_addr, fwd_addr, taken;
    logic [2:0] fwd_entry;
    logic [3:0] stall;
    int n_mismatch = 0, samples_checked = 0, cyc = 0;
    iart_top dut_u (.ref_clk, .reset_n, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en,
        .reg_rdata, .reg_rd_hit, .req_valid, .req_addr, .req_rnw, .req_ready, .req_nack,
        .fwd_valid, .fwd_addr, .fwd_rnw, .fwd_entry, .fwd_ready);
    iart_chan_model chan_u (.ref_clk, .reset_n, .fwd_valid, .fwd_addr, .stall,
        .fwd_ready, .taken_addr(taken));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) #1 reg_wr_en = 1; reg_addr = a; reg_wdata = d;
        @(posedge ref_clk) #1 reg_wr_en = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic h);
        @(posedge ref_clk) #1 reg_rd_en = 1; reg_addr = a;
        @(posedge ref_clk) #1 reg_rd_en = 0;
        chk(reg_rdata, d);
        chk({7'h0, reg_rd_hit}, {7'h0, h});
    endtask
    // One lookup; checks refusal, target, entry and delivery
    task automatic look(input logic [6:0] a, input logic r, input logic nk, input logic [6:0] t,
        input logic [2:0] e);
        int i;
        @(posedge ref_clk) #1 req_valid = 1; req_addr = a; req_rnw = r;
        @(posedge ref_clk) #1 req_valid = 0;
        for (i = 0; i < 40 && req_nack !== 1'b1 && fwd_valid !== 1'b1; i++) @(posedge ref_clk) #1;
        chk({7'h0, req_nack}, {7'h0, nk});
        if (!nk) chk({1'b0, fwd_addr}, {1'b0, t});
        if (!nk) chk({5'h0, fwd_entry}, {5'h0, e});
        if (!nk) chk({7'h0, fwd_rnw}, {7'h0, r});
        for (i = 0; i < 40 && !(req_ready === 1'b1 && fwd_valid === 1'b0); i++) @(posedge ref_clk) #1;
        if (!nk) chk({1'b0, taken}, {1'b0, t});
    endtask
    initial begin
        ref_clk = 0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_mismatch++;
            close_out();
        end
    end
    initial begin
        {reset_n, reg_wr_en, reg_rd_en, req_valid, req_rnw} = 5'h0;
        {reg_addr, reg_wdata, req_addr, stall} = 27'h0;
        repeat (4) @(posedge ref_clk);
        #1 reset_n = 1;
        wr(8'h18, 8'haa);
        for (int o = 8; o < 25; o++) rd(8'(o), 8'h00, o < 24);
        wr(8'h0f, 8'hff);
        rd(8'h0f, 8'hfe, 1'b1);
        for (int n = 0; n < 8; n++) begin
            wr(8'h08 + 8'(n), n < 7 ? {7'h30 + 7'(n), 1'b1} : 8'h00);
            wr(8'h10 + 8'(n), {7'h50 + 7'(n), 1'b1});
        end
        for (int n = 0; n < 7; n++) begin
            rd(8'h10 + 8'(n), {7'h50 + 7'(n), 1'b0}, 1'b1);
            stall = 4'(n);
            look(7'h50 + 7'(n), n[0], 1'b0, 7'h30 + 7'(n), 3'(n));
        end
        look(7'h57, 1'b0, 1'b1, 7'h00, 3'h0);
        wr(8'h0f, 8'h7e);
        look(7'h57, 1'b1, 1'b0, 7'h3f, 3'h7);
        wr(8'h12, 8'h01);
        rd(8'h12, 8'h00, 1'b1);
        look(7'h52, 1'b0, 1'b1, 7'h00, 3'h0);
        look(7'h00, 1'b0, 1'b1, 7'h00, 3'h0);
        close_out();
    end
endmodule
bind iart_top iart_monitor mon_u (.ref_clk, .reset_n, .reg_addr, .reg_rd_en, .reg_rdata,
    .reg_rd_hit, .req_valid, .req_rnw, .req_ready, .req_nack, .fwd_valid, .fwd_addr,
    .fwd_rnw, .fwd_entry, .fwd_ready);
`default_nettype wire
